// ===== hdl/gptc_pkg.sv
// Package with command codes, field positions, reset values and timing counts.
package gptc_pkg;
  localparam int          CLK_PERIOD_NS   = 10;
  localparam logic [3:0]  CMD_MODE        = 4'h2;
  localparam logic [3:0]  CMD_ONOFF       = 4'h3;
  localparam logic [3:0]  CMD_SPARK       = 4'h4;
  localparam logic [3:0]  CMD_SHORT_THR   = 4'h5;
  localparam int          SPK_EOS_LSB     = 0;
  localparam int          SPK_GAIN_BIT    = 6;
  localparam int          SPK_MAX_CURRENT_TRIP_LSB    = 8;
  localparam int          ONOFF_LSD_LSB   = 0;
  localparam int          ONOFF_GATE_LSB  = 4;
  localparam int          MODE_GP_LSB     = 0;
  localparam int          SHORT_THR_LSB   = 0;
  localparam logic [2:0]  SHORT_THR_MAX   = 3'h5;
  localparam logic [2:0]  SHORT_THR_RST   = 3'h3;
  localparam logic [3:0]  MAX_CURRENT_TRIP_THR_RST    = 4'h0;
  localparam logic [1:0]  EOS_FILT_RST    = 2'h0;
  localparam logic        GAIN_RST        = 1'b0;
  localparam logic [3:0]  GP_MODE_RST     = 4'h0;
  localparam int          EOS_T1_NS       = 4000;
  localparam int          EOS_T2_NS       = 16000;
  localparam int          EOS_T3_NS       = 32000;
  localparam logic [11:0] EOS_T1_CYC      = 12'(EOS_T1_NS / CLK_PERIOD_NS);
  localparam logic [11:0] EOS_T2_CYC      = 12'(EOS_T2_NS / CLK_PERIOD_NS);
  localparam logic [11:0] EOS_T3_CYC      = 12'(EOS_T3_NS / CLK_PERIOD_NS);
endpackage : gptc_pkg

// ===== hdl/gptc_core.sv
// Trip, end-of-spark filter, driver control and load fault logic for four gate pre-drivers.
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// - Synchronised over-current forces off every ignition-configured gate driver.
// - Over-current trip sets the trip flag and, outside ten-coil mode, drives the trip pin high.
// - Trip flag clears only after condition ended and status was read.
// - Spark command bit 6 selects gain two; reset gives gain one.
// - In ten-coil mode trip pin is input and acts as internal trip.
// - Spark command bits 11 to 8 set the trip threshold code.
// - Two-bit filter selects 0, 4, 16 or 32 us end-of-spark window.
// - Each driver may be general purpose, driven by pin or command.
// - On/off command bits 4 to 7 switch general-purpose drivers.
// - Ignition drivers follow their pin only and ignore command bits.
// - On/off command also carries low-side injector driver bits.
// - Off general-purpose driver with low drain feedback reports open load.
// - On general-purpose driver above short threshold reports short.
// - Short threshold codes 0 to 5 load; codes 6 and 7 are ignored.
// - Faults are visible only as status bits read by the host.
module gptc_core
  import gptc_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        clk_en,
  input  wire logic        cmd_valid,
  input  wire logic [3:0]  cmd_code,
  input  wire logic [11:0] cmd_data,
  input  wire logic        status_read,
  input  wire logic        ten_coil_mode,
  input  wire logic [3:0]  parallel_gate_input,
  input  wire logic        trip_cmp_in,
  input  wire logic        trip_pin_in,
  input  wire logic        spark_cmp_in,
  input  wire logic [3:0]  open_cmp_in,
  input  wire logic [3:0]  short_cmp_in,
  output logic      [3:0]  gate_drive_out,
  output logic      [3:0]  integrated_low_side,
  output logic             max_current_trip,
  output logic             trip_pin_oe_n,
  output logic             trip_flag,
  output logic      [3:0]  open_fault,
  output logic      [3:0]  short_fault,
  output logic      [3:0]  general_gate_mode,
  output logic             gain_sel,
  output logic      [3:0]  max_thr_code,
  output logic      [1:0]  eos_filt_code,
  output logic      [2:0]  short_thr_code,
  output logic             end_of_spark
);
  logic [10:0] sync1_reg;
  logic [10:0] sync2_reg;
  logic        trip_act;
  logic        spk_s;
  logic [3:0]  open_s;
  logic [3:0]  short_s;
  logic [3:0]  gate_reg,  gate_next;
  logic [3:0]  lsd_reg,   lsd_next;
  logic [3:0]  spi_on_reg, spi_on_next;
  logic [3:0]  gp_reg,    gp_next;
  logic        gain_reg,  gain_next;
  logic [3:0]  max_current_trip_reg,  max_current_trip_next;
  logic [1:0]  eos_reg,   eos_next;
  logic [2:0]  sthr_reg,  sthr_next;
  logic        tpin_reg,  tpin_next;
  logic        toe_reg,   toe_next;
  logic        tflag_reg, tflag_next;
  logic        tpend_reg, tpend_next;
  logic [3:0]  open_reg,  open_next;
  logic [3:0]  short_reg, short_next;
  logic [11:0] ecnt_reg,  ecnt_next;
  logic        eosd_reg,  eosd_next;
  logic [11:0] ewin;

  // Two-stage synchroniser for all comparator and trip pin inputs.
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync1_reg <= 11'h000;
      sync2_reg <= 11'h000;
    end
    else if (clk_en)
    begin
      sync1_reg <= {trip_cmp_in, trip_pin_in, spark_cmp_in, open_cmp_in, short_cmp_in};
      sync2_reg <= sync1_reg;
    end
  end

  assign spk_s   = sync2_reg[8];
  assign open_s  = sync2_reg[7:4];
  assign short_s = sync2_reg[3:0];
  // Own comparator is disabled in ten-coil mode; the pin then carries the trip.
  assign trip_act = ten_coil_mode ? sync2_reg[9] : sync2_reg[10];

  always_comb
  begin
    case (eos_reg)
      2'h1:    ewin = EOS_T1_CYC;
      2'h2:    ewin = EOS_T2_CYC;
      2'h3:    ewin = EOS_T3_CYC;
      default: ewin = 12'h000;
    endcase
  end

  // Configuration written by host commands.
  always_comb
  begin
    gp_next     = gp_reg;
    spi_on_next = spi_on_reg;
    lsd_next    = lsd_reg;
    gain_next   = gain_reg;
    max_current_trip_next   = max_current_trip_reg;
    eos_next    = eos_reg;
    sthr_next   = sthr_reg;
    if (cmd_valid)
    begin
      case (cmd_code)
        CMD_MODE:  gp_next = cmd_data[MODE_GP_LSB +: 4];
        CMD_ONOFF:
        begin
          spi_on_next = cmd_data[ONOFF_GATE_LSB +: 4];
          lsd_next    = cmd_data[ONOFF_LSD_LSB +: 4];
        end
        CMD_SPARK:
        begin
          gain_next = cmd_data[SPK_GAIN_BIT];
          max_current_trip_next = cmd_data[SPK_MAX_CURRENT_TRIP_LSB +: 4];
          eos_next  = cmd_data[SPK_EOS_LSB +: 2];
        end
        CMD_SHORT_THR:
        begin
          if (cmd_data[SHORT_THR_LSB +: 3] <= SHORT_THR_MAX)
            sthr_next = cmd_data[SHORT_THR_LSB +: 3];
        end
        default: gp_next = gp_reg;
      endcase
    end
  end

  // Driver outputs, trip handling, fault flags and end-of-spark filter.
  always_comb
  begin
    for (int i = 0; i < 4; i++)
    begin
      if (gp_reg[i])
        gate_next[i] = parallel_gate_input[i] | spi_on_reg[i];
      else
        gate_next[i] = parallel_gate_input[i] & ~trip_act;
    end
    tpin_next  = ~ten_coil_mode & trip_act;
    toe_next   = ten_coil_mode;
    tpend_next = tpend_reg | (status_read & tflag_reg);
    tflag_next = tflag_reg;
    if (trip_act)
      tflag_next = 1'b1;
    else if (tflag_reg && (tpend_reg || status_read))
    begin
      tflag_next = 1'b0;
      tpend_next = 1'b0;
    end
    if (!tflag_reg && !trip_act)
      tpend_next = 1'b0;
    // Set wins over clear on a status read.
    open_next  = (status_read ? 4'h0 : open_reg) | (gp_reg & ~gate_reg & open_s);
    short_next = (status_read ? 4'h0 : short_reg) | (gp_reg & gate_reg & short_s);
    if (!spk_s)
    begin
      ecnt_next = 12'h000;
      eosd_next = 1'b0;
    end
    else if (ecnt_reg >= ewin)
    begin
      ecnt_next = ecnt_reg;
      eosd_next = 1'b1;
    end
    else
    begin
      ecnt_next = ecnt_reg + 12'h001;
      eosd_next = 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      gp_reg     <= GP_MODE_RST;
      spi_on_reg <= 4'h0;
      lsd_reg    <= 4'h0;
      gain_reg   <= GAIN_RST;
      max_current_trip_reg   <= MAX_CURRENT_TRIP_THR_RST;
      eos_reg    <= EOS_FILT_RST;
      sthr_reg   <= SHORT_THR_RST;
      gate_reg   <= 4'h0;
      tpin_reg   <= 1'b0;
      toe_reg    <= 1'b1;
      tflag_reg  <= 1'b0;
      tpend_reg  <= 1'b0;
      open_reg   <= 4'h0;
      short_reg  <= 4'h0;
      ecnt_reg   <= 12'h000;
      eosd_reg   <= 1'b0;
    end
    else if (clk_en)
    begin
      gp_reg     <= gp_next;
      spi_on_reg <= spi_on_next;
      lsd_reg    <= lsd_next;
      gain_reg   <= gain_next;
      max_current_trip_reg   <= max_current_trip_next;
      eos_reg    <= eos_next;
      sthr_reg   <= sthr_next;
      gate_reg   <= gate_next;
      tpin_reg   <= tpin_next;
      toe_reg    <= toe_next;
      tflag_reg  <= tflag_next;
      tpend_reg  <= tpend_next;
      open_reg   <= open_next;
      short_reg  <= short_next;
      ecnt_reg   <= ecnt_next;
      eosd_reg   <= eosd_next;
    end
  end

  assign gate_drive_out      = gate_reg;
  assign integrated_low_side = lsd_reg;
  assign max_current_trip    = tpin_reg;
  assign trip_pin_oe_n       = toe_reg;
  assign trip_flag           = tflag_reg;
  assign open_fault          = open_reg;
  assign short_fault         = short_reg;
  assign general_gate_mode   = gp_reg;
  assign gain_sel            = gain_reg;
  assign max_thr_code        = max_current_trip_reg;
  assign eos_filt_code       = eos_reg;
  assign short_thr_code      = sthr_reg;
  assign end_of_spark        = eosd_reg;

  chk_trip_forces_off: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && trip_act |=> (gate_drive_out & ~$past(gp_reg)) == 4'h0)
    else $error("Ignition driver on during trip.");
  chk_trip_sets_flag: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && trip_act |=> trip_flag && (max_current_trip == !$past(ten_coil_mode)))
    else $error("Trip flag or pin not raised.");
  chk_flag_holds_unread: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && trip_flag && !tpend_reg && !status_read |=> trip_flag)
    else $error("Trip flag cleared without read.");
  chk_gain_write: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && cmd_valid && cmd_code == CMD_SPARK |=> gain_sel == $past(cmd_data[SPK_GAIN_BIT]))
    else $error("Gain select not loaded.");
  chk_tencoil_pin_in: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && ten_coil_mode |=> trip_pin_oe_n && !max_current_trip)
    else $error("Trip pin driven in ten-coil mode.");
  chk_thr_write: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && cmd_valid && cmd_code == CMD_SPARK |=> max_thr_code == $past(cmd_data[11:8]))
    else $error("Trip threshold not loaded.");
  chk_eos_none: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && !spk_s |=> !end_of_spark)
    else $error("End of spark without current drop.");
  chk_ign_ignores_spi: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && !gp_reg[1] && !parallel_gate_input[1] |=> !gate_drive_out[1])
    else $error("Ignition driver followed command bit.");
  chk_gp_onoff: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && gp_reg[0] && spi_on_reg[0] |=> gate_drive_out[0])
    else $error("General driver not on.");
  chk_open_flag: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && gp_reg[2] && !gate_reg[2] && open_s[2] |=> open_fault[2])
    else $error("Open load not flagged.");
  chk_short_flag: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && gp_reg[0] && gate_reg[0] && short_s[0] |=> short_fault[0])
    else $error("Short not flagged.");
  chk_short_thr_keep: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && cmd_valid && cmd_code == CMD_SHORT_THR && cmd_data[2:1] == 2'h3
      |=> $stable(short_thr_code))
    else $error("Short threshold changed by reserved code.");
endmodule : gptc_core
`default_nettype wire

// ===== sim/gptc_host.sv
// Host model that strobes commands and fault status reads into the block.
`timescale 1ns/100ps
`default_nettype none
module gptc_host (
  input  wire logic        core_clk,
  output logic             cmd_valid   = 1'b0,
  output logic      [3:0]  cmd_code    = 4'h0,
  output logic      [11:0] cmd_data    = 12'h000,
  output logic             status_read = 1'b0
);
  // Sends one command as a single-cycle strobe, scrambles the payload and idles one cycle.
  task automatic cmd(input logic [3:0] code, input logic [11:0] data);
    cmd_valid = 1'b1;
    cmd_code  = code;
    cmd_data  = data;
    @(posedge core_clk);
    #1;
    cmd_valid = 1'b0;
    cmd_code  = ~code;
    cmd_data  = ~data;
    @(posedge core_clk);
    #1;
  endtask : cmd
  // Polls the fault status with a single-cycle read strobe.
  task automatic rd();
    status_read = 1'b1;
    @(posedge core_clk);
    #1;
    status_read = 1'b0;
  endtask : rd
endmodule : gptc_host
`default_nettype wire

// ===== sim/gptc_bench.sv
// Self-checking bench for the gate pre-driver trip and command block.
`timescale 1ns/100ps
`default_nettype none
module gptc_bench import gptc_pkg::*;;
  logic        core_clk = 1'b0;
  logic        rst_n, clk_en, cmd_valid, status_read, ten_coil_mode, trip_cmp_in, trip_pin_in;
  logic        spark_cmp_in, max_current_trip, trip_pin_oe_n, trip_flag, gain_sel, end_of_spark;
  logic [3:0]  cmd_code, parallel_gate_input, open_cmp_in, short_cmp_in, gate_drive_out;
  logic [3:0]  integrated_low_side, open_fault, short_fault, general_gate_mode, max_thr_code;
  logic [1:0]  eos_filt_code;
  logic [2:0]  short_thr_code, sthr;
  logic [11:0] cmd_data, d;
  int          n_fail, checks_done, seed;
  string       qn[$];
  logic [11:0] qv[$];
  string       nn;
  logic [11:0] nv;
  event        probe;
  always #(CLK_PERIOD_NS / 2) core_clk = ~core_clk;
  gptc_host host_u (.core_clk, .cmd_valid, .cmd_code, .cmd_data, .status_read);
  gptc_core dut_u (.core_clk, .rst_n, .clk_en, .cmd_valid, .cmd_code, .cmd_data, .status_read,
    .ten_coil_mode, .parallel_gate_input, .trip_cmp_in, .trip_pin_in, .spark_cmp_in,
    .open_cmp_in, .short_cmp_in, .gate_drive_out, .integrated_low_side, .max_current_trip,
    .trip_pin_oe_n, .trip_flag, .open_fault, .short_fault, .general_gate_mode, .gain_sel,
    .max_thr_code, .eos_filt_code, .short_thr_code, .end_of_spark);
  function automatic logic [11:0] seen(string n);
    case (n)
      "cfg":   return 12'({gain_sel, max_thr_code, eos_filt_code, short_thr_code});
      "trip":  return 12'({max_current_trip, trip_pin_oe_n, trip_flag});
      "flt":   return 12'({open_fault, short_fault});
      "gate":  return 12'(gate_drive_out);
      "lsd":   return 12'(integrated_low_side);
      "mode":  return 12'(general_gate_mode);
      default: return 12'(end_of_spark);
    endcase
  endfunction : seen
  function automatic logic [11:0] cfg(logic [11:0] s, logic [2:0] t);
    return 12'({s[SPK_GAIN_BIT], s[SPK_MAX_CURRENT_TRIP_LSB +: 4], s[SPK_EOS_LSB +: 2], t});
  endfunction : cfg
  task automatic check(string n, logic [11:0] s, logic [11:0] e);
    checks_done++;
    if (s !== e)
    begin
      n_fail++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask : check
  task automatic note(string n, logic [11:0] v);
    qn.push_back(n);
    qv.push_back(v);
    ->probe;
  endtask : note
  task automatic tick(int k);
    repeat (k) @(posedge core_clk);
    #1;
  endtask : tick
  task automatic results();
    $display("Counts: %0d checks, %0d mismatches", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : results
  // Checks every queued expectation, oldest first, whenever a result is announced.
  always @(probe)
  begin
    while (qn.size() > 0)
    begin
      nn = qn.pop_front();
      nv = qv.pop_front();
      check(nn, seen(nn), nv);
    end
  end
  initial
  begin
    #(CLK_PERIOD_NS * 20000);
    n_fail++;
    results();
  end
  initial
  begin
    {n_fail, checks_done, seed} = {32'd0, 32'd0, 32'h00f6e93a};
    {rst_n, ten_coil_mode, trip_cmp_in, trip_pin_in, spark_cmp_in} = 5'h00;
    {open_cmp_in, short_cmp_in, parallel_gate_input} = 12'h00A;
    clk_en = 1'b1;
    sthr = SHORT_THR_RST;
    tick(4);
    rst_n = 1'b1;
    note("cfg", 12'({GAIN_RST, MAX_CURRENT_TRIP_THR_RST, EOS_FILT_RST, SHORT_THR_RST}));
    note("mode", 12'(GP_MODE_RST));
    tick(2);
    note("trip", 12'h000);
    repeat (4)
    begin
      d = 12'($random(seed));
      host_u.cmd(CMD_SPARK, d);
      note("cfg", cfg(d, sthr));
    end
    for (int c = 0; c < 8; c++)
    begin
      host_u.cmd(CMD_SHORT_THR, {d[11:3], 3'(c)});
      sthr = (c <= SHORT_THR_MAX) ? 3'(c) : sthr;
      note("cfg", cfg(d, sthr));
    end
    $display("settings test done");
    host_u.cmd(CMD_MODE, 12'h005);
    note("mode", 12'h005);
    host_u.cmd(CMD_ONOFF, 12'h0A9);
    note("lsd", 12'h009);
    tick(1);
    note("gate", 12'h00A);
    host_u.cmd(CMD_ONOFF, 12'h0F6);
    parallel_gate_input = 4'h0;
    tick(1);
    note("gate", 12'h005);
    parallel_gate_input = 4'hA;
    tick(1);
    note("gate", 12'h00F);
    $display("driver test done");
    trip_cmp_in = 1'b1;
    tick(2);
    note("trip", 12'h000);
    tick(1);
    note("trip", 12'h005);
    note("gate", 12'h005);
    host_u.rd();
    note("trip", 12'h005);
    trip_cmp_in = 1'b0;
    tick(3);
    note("trip", 12'h000);
    trip_cmp_in = 1'b1;
    tick(3);
    trip_cmp_in = 1'b0;
    tick(4);
    note("trip", 12'h001);
    note("gate", 12'h00F);
    host_u.rd();
    tick(1);
    note("trip", 12'h000);
    $display("trip test done");
    host_u.cmd(CMD_ONOFF, 12'h010);
    {open_cmp_in, short_cmp_in} = 8'hFF;
    tick(4);
    note("flt", 12'h041);
    {open_cmp_in, short_cmp_in} = 8'h00;
    tick(3);
    note("flt", 12'h041);
    host_u.rd();
    note("flt", 12'h000);
    $display("fault test done");
    host_u.cmd(CMD_SPARK, 12'h000);
    spark_cmp_in = 1'b1;
    tick(5);
    note("end", 12'h001);
    spark_cmp_in = 1'b0;
    host_u.cmd(CMD_SPARK, 12'h001);
    tick(4);
    spark_cmp_in = 1'b1;
    tick(300);
    note("end", 12'h000);
    tick(200);
    note("end", 12'h001);
    $display("spark filter test done");
    ten_coil_mode = 1'b1;
    trip_pin_in = 1'b1;
    tick(4);
    note("gate", 12'h001);
    trip_pin_in = 1'b0;
    host_u.rd();
    tick(4);
    note("trip", 12'h002);
    note("gate", 12'h00B);
    $display("ten-coil test done");
    clk_en = 1'b0;
    parallel_gate_input = 4'h0;
    host_u.cmd(CMD_MODE, 12'h00F);
    note("mode", 12'h005);
    note("gate", 12'h00B);
    clk_en = 1'b1;
    tick(1);
    note("gate", 12'h001);
    $display("clock enable test done");
    results();
  end
endmodule : gptc_bench
`default_nettype wire
